/* gvt_pkg.sv */
// Function
// - Row supply select bit: 0 core supply, 1 aux logic supply; resets 0
// - Column supply select bit: 0 core supply, 1 aux logic supply; resets 0
// - Row output level bit drives row low on 0, high on 1
// - Column output level bit drives column low or high; resets to ones
// - Columns 7 to 4 only release on 1; external pull-up gives high
// - Translator enable bit n couples column n with row n
// - Linked pair takes direction from column direction bit n only
// - Translator enable resets with all eight pairs unlinked
// - Column direction bit: 0 input, 1 output; resets to input
// - Columns 7 to 4 are always open-drain; mode bits not writable
package gvt_pkg;
  localparam logic [7:0] ROW_DIR_OFS   = 8'h34;
  localparam logic [7:0] COL_DIR_OFS   = 8'h35;
  localparam logic [7:0] ROW_MODE_OFS  = 8'h36;
  localparam logic [7:0] COL_MODE_OFS  = 8'h37;
  localparam logic [7:0] ROW_SUP_OFS   = 8'h38;
  localparam logic [7:0] COL_SUP_OFS   = 8'h39;
  localparam logic [7:0] ROW_LVL_OFS   = 8'h3a;
  localparam logic [7:0] COL_LVL_OFS   = 8'h3b;
  localparam logic [7:0] PAIR_LT_OFS   = 8'h3c;
  localparam logic [7:0] ROW_DIR_RST   = 8'h00;
  localparam logic [7:0] COL_DIR_RST   = 8'h00;
  localparam logic [7:0] ROW_MODE_RST  = 8'hff;
  localparam logic [7:0] COL_MODE_RST  = 8'h00;
  localparam logic [7:0] ROW_SUP_RST   = 8'h00;
  localparam logic [7:0] COL_SUP_RST   = 8'h00;
  localparam logic [7:0] ROW_LVL_RST   = 8'hff;
  localparam logic [7:0] COL_LVL_RST   = 8'hff;
  localparam logic [7:0] PAIR_LT_RST   = 8'h00;
  localparam logic [7:0] COL_MODE_WMASK = 8'h0f;
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00;
  localparam int         PAIR_COUNT     = 8;
  localparam int         OD_FIXED_FIRST = 4;
endpackage

/* gvt_sync.sv */
`timescale 1ns/1ns
module gvt_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

/* gvt_pin_pair.sv */
`timescale 1ns/1ns
module gvt_pin_pair (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic lt_en,
  input  wire logic row_dir,
  input  wire logic col_dir,
  input  wire logic row_od,
  input  wire logic col_od,
  input  wire logic row_val,
  input  wire logic col_val,
  input  wire logic row_in,
  input  wire logic col_in,
  output logic      row_out,
  output logic      row_oe,
  output logic      col_out,
  output logic      col_oe
);
  logic row_drive;
  logic col_drive;
  logic row_level;
  logic col_level;

  // Linked pair: column direction alone decides which side drives
  assign row_drive = lt_en ? ~col_dir : row_dir;
  assign col_drive = col_dir;
  assign row_level = lt_en ? col_in : row_val;
  assign col_level = lt_en ? row_in : col_val;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      row_out <= 1'b0;
      row_oe  <= 1'b0;
      col_out <= 1'b0;
      col_oe  <= 1'b0;
    end else begin
      // Open-drain only pulls low and releases for high
      row_out <= row_od ? 1'b0 : row_level;
      row_oe  <= row_drive & (row_od ? ~row_level : 1'b1);
      col_out <= col_od ? 1'b0 : col_level;
      col_oe  <= col_drive & (col_od ? ~col_level : 1'b1);
    end
  end

  pair_to_col_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      $past(lt_en & col_dir & ~col_od) |->
        col_oe && (col_out == $past(row_in)) && !row_oe)
    else $error("Linked pair did not copy row level to column");

  pair_to_row_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      $past(lt_en & ~col_dir & ~row_od & ~row_dir) |->
        row_oe && (row_out == $past(col_in)) && !col_oe)
    else $error("Linked pair ignored column direction");

  row_drive_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      $past(~lt_en & row_dir & ~row_od) |->
        row_oe && (row_out == $past(row_val)))
    else $error("Row output does not follow its level bit");

  col_drive_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      $past(~lt_en & col_dir & ~col_od) |->
        col_oe && (col_out == $past(col_val)))
    else $error("Column output does not follow its level bit");

  col_input_a: assert property (
    @(posedge clk) disable iff (!rst_n) $past(~col_dir) |-> !col_oe)
    else $error("Input column is being driven");

  od_release_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      $past(col_od) |-> !col_out && (col_oe == $past(col_dir & ~col_level)))
    else $error("Open-drain column drove high");
endmodule

/* gvt_top.sv */
`timescale 1ns/1ns
module gvt_top (
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic [7:0] ROW_IN,
  output logic      [7:0] ROW_OUT,
  output logic      [7:0] ROW_OE,
  input  wire logic [7:0] COL_IN,
  output logic      [7:0] COL_OUT,
  output logic      [7:0] COL_OE,
  output logic      [7:0] ROW_SUPPLY_SEL,
  output logic      [7:0] COL_SUPPLY_SEL
);
  logic [7:0] row_dir_reg;
  logic [7:0] col_dir_reg;
  logic [7:0] row_mode_reg;
  logic [7:0] col_mode_reg;
  logic [7:0] row_level_reg;
  logic [7:0] col_level_reg;
  logic [7:0] pair_lt_reg;
  logic [7:0] rdata_next;
  logic [7:0] row_in_s;
  logic [7:0] col_in_s;
  logic [7:0] col_od;
  logic [7:0] row_od;
  logic       wr_row_dir;
  logic       wr_col_dir;
  logic       wr_row_mode;
  logic       wr_col_mode;
  logic       wr_row_sup;
  logic       wr_col_sup;
  logic       wr_row_lvl;
  logic       wr_col_lvl;
  logic       wr_pair_lt;

  assign wr_row_dir  = REG_WR && (REG_ADDR == gvt_pkg::ROW_DIR_OFS);
  assign wr_col_dir  = REG_WR && (REG_ADDR == gvt_pkg::COL_DIR_OFS);
  assign wr_row_mode = REG_WR && (REG_ADDR == gvt_pkg::ROW_MODE_OFS);
  assign wr_col_mode = REG_WR && (REG_ADDR == gvt_pkg::COL_MODE_OFS);
  assign wr_row_sup  = REG_WR && (REG_ADDR == gvt_pkg::ROW_SUP_OFS);
  assign wr_col_sup  = REG_WR && (REG_ADDR == gvt_pkg::COL_SUP_OFS);
  assign wr_row_lvl  = REG_WR && (REG_ADDR == gvt_pkg::ROW_LVL_OFS);
  assign wr_col_lvl  = REG_WR && (REG_ADDR == gvt_pkg::COL_LVL_OFS);
  assign wr_pair_lt  = REG_WR && (REG_ADDR == gvt_pkg::PAIR_LT_OFS);

  // Unmapped offsets read as zero; writes to them are dropped
  assign rdata_next =
    (REG_ADDR == gvt_pkg::ROW_DIR_OFS)  ? row_dir_reg    :
    (REG_ADDR == gvt_pkg::COL_DIR_OFS)  ? col_dir_reg    :
    (REG_ADDR == gvt_pkg::ROW_MODE_OFS) ? row_mode_reg   :
    (REG_ADDR == gvt_pkg::COL_MODE_OFS) ? col_mode_reg   :
    (REG_ADDR == gvt_pkg::ROW_SUP_OFS)  ? ROW_SUPPLY_SEL :
    (REG_ADDR == gvt_pkg::COL_SUP_OFS)  ? COL_SUPPLY_SEL :
    (REG_ADDR == gvt_pkg::ROW_LVL_OFS)  ? row_level_reg  :
    (REG_ADDR == gvt_pkg::COL_LVL_OFS)  ? col_level_reg  :
    (REG_ADDR == gvt_pkg::PAIR_LT_OFS)  ? pair_lt_reg    :
    gvt_pkg::UNMAPPED_DATA;

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      row_dir_reg <= gvt_pkg::ROW_DIR_RST;
    end else if (wr_row_dir) begin
      row_dir_reg <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      col_dir_reg <= gvt_pkg::COL_DIR_RST;
    end else if (wr_col_dir) begin
      col_dir_reg <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      row_mode_reg <= gvt_pkg::ROW_MODE_RST;
    end else if (wr_row_mode) begin
      row_mode_reg <= REG_WDATA;
    end
  end

  // Upper mode bits are not writable, so those columns stay open-drain
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      col_mode_reg <= gvt_pkg::COL_MODE_RST;
    end else if (wr_col_mode) begin
      col_mode_reg <= REG_WDATA & gvt_pkg::COL_MODE_WMASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      ROW_SUPPLY_SEL <= gvt_pkg::ROW_SUP_RST;
    end else if (wr_row_sup) begin
      ROW_SUPPLY_SEL <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      COL_SUPPLY_SEL <= gvt_pkg::COL_SUP_RST;
    end else if (wr_col_sup) begin
      COL_SUPPLY_SEL <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      row_level_reg <= gvt_pkg::ROW_LVL_RST;
    end else if (wr_row_lvl) begin
      row_level_reg <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      col_level_reg <= gvt_pkg::COL_LVL_RST;
    end else if (wr_col_lvl) begin
      col_level_reg <= REG_WDATA;
    end
  end

  // Pairs come up unlinked so every pin acts alone until software asks
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      pair_lt_reg <= gvt_pkg::PAIR_LT_RST;
    end else if (wr_pair_lt) begin
      pair_lt_reg <= REG_WDATA;
    end
  end

  // Read data holds between reads, so a slow master may fetch it late
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_next;
    end
  end

  // Pins are asynchronous to MCLK, so a translated level lags by a few cycles
  gvt_sync #(.WIDTH(8)) u_row_sync (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .async_in (ROW_IN),
    .sync_out (row_in_s)
  );

  gvt_sync #(.WIDTH(8)) u_col_sync (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .async_in (COL_IN),
    .sync_out (col_in_s)
  );

  // Mode bit 0 means open-drain; upper columns are forced open-drain
  assign row_od = ~row_mode_reg;
  assign col_od = ~(col_mode_reg & gvt_pkg::COL_MODE_WMASK);

  for (genvar n = 0; n < gvt_pkg::PAIR_COUNT; n++) begin : g_pair
    gvt_pin_pair u_pair (
      .clk     (MCLK),
      .rst_n   (RESET_N),
      .lt_en   (pair_lt_reg[n]),
      .row_dir (row_dir_reg[n]),
      .col_dir (col_dir_reg[n]),
      .row_od  (row_od[n]),
      .col_od  (col_od[n]),
      .row_val (row_level_reg[n]),
      .col_val (col_level_reg[n]),
      .row_in  (row_in_s[n]),
      .col_in  (col_in_s[n]),
      .row_out (ROW_OUT[n]),
      .row_oe  (ROW_OE[n]),
      .col_out (COL_OUT[n]),
      .col_oe  (COL_OE[n])
    );
  end

  row_sup_reset_a: assert property (
    @(posedge MCLK) !RESET_N |=> ROW_SUPPLY_SEL == 8'h00)
    else $error("Row supply select not cleared by reset");

  col_sup_reset_a: assert property (
    @(posedge MCLK) !RESET_N |=> COL_SUPPLY_SEL == 8'h00)
    else $error("Column supply select not cleared by reset");

  lt_reset_a: assert property (
    @(posedge MCLK) !RESET_N |=> pair_lt_reg == 8'h00 && COL_OE == 8'h00)
    else $error("Translator pairs not disabled after reset");

  col_sup_write_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      wr_col_sup |=> COL_SUPPLY_SEL == $past(REG_WDATA))
    else $error("Column supply select write lost");

  lt_write_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      wr_pair_lt |=> pair_lt_reg == $past(REG_WDATA))
    else $error("Translator enable write lost");

  od_mode_fixed_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      col_mode_reg[7:4] == 4'h0 && COL_OUT[7:4] == 4'h0)
    else $error("Upper column left open-drain mode");

  row_lvl_drive_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      (wr_row_lvl && pair_lt_reg == 8'h00 && row_dir_reg == 8'hff &&
       row_mode_reg == 8'hff) ##1 (pair_lt_reg == 8'h00 &&
       row_dir_reg == 8'hff && row_mode_reg == 8'hff)
      |=> ROW_OUT == $past(REG_WDATA, 2) && ROW_OE == 8'hff)
    else $error("Row pins do not show the written level");

  row_sup_write_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      wr_row_sup |=> ROW_SUPPLY_SEL == $past(REG_WDATA))
    else $error("Row supply select write lost");

  col_dir_write_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      wr_col_dir |=> col_dir_reg == $past(REG_WDATA))
    else $error("Column direction write lost");

  row_lvl_write_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      wr_row_lvl |=> row_level_reg == $past(REG_WDATA))
    else $error("Row level write lost");

  col_lvl_write_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      wr_col_lvl |=> col_level_reg == $past(REG_WDATA))
    else $error("Column level write lost");

  col_mode_mask_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      wr_col_mode |=> col_mode_reg == {4'h0, $past(REG_WDATA[3:0])})
    else $error("Upper column mode bits took a write");

  col_dir_reset_a: assert property (
    @(posedge MCLK) !RESET_N |=> col_dir_reg == 8'h00)
    else $error("Columns not inputs after reset");

  col_lvl_reset_a: assert property (
    @(posedge MCLK) !RESET_N |=> col_level_reg == 8'hff)
    else $error("Column levels not high after reset");

  row_sup_read_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      REG_RD && REG_ADDR == gvt_pkg::ROW_SUP_OFS |=>
        REG_RDATA == $past(ROW_SUPPLY_SEL))
    else $error("Row supply select read back wrong");

  col_sup_read_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      REG_RD && REG_ADDR == gvt_pkg::COL_SUP_OFS |=>
        REG_RDATA == $past(COL_SUPPLY_SEL))
    else $error("Column supply select read back wrong");

  lt_read_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      REG_RD && REG_ADDR == gvt_pkg::PAIR_LT_OFS |=>
        REG_RDATA == $past(pair_lt_reg))
    else $error("Translator enable read back wrong");

  unlinked_row_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      pair_lt_reg == 8'h00 && row_mode_reg == 8'hff |=>
        ROW_OUT == $past(row_level_reg) && ROW_OE == $past(row_dir_reg))
    else $error("Unlinked row does not follow its own registers");

  unlinked_col_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      pair_lt_reg[3:0] == 4'h0 && col_mode_reg[3:0] == 4'hf |=>
        COL_OUT[3:0] == $past(col_level_reg[3:0]))
    else $error("Unlinked column does not follow its level");

  linked_row_oe_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      pair_lt_reg == 8'hff && row_mode_reg == 8'hff |=>
        ROW_OE == ~$past(col_dir_reg))
    else $error("Linked row drive not set by column direction");

  linked_col_oe_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      pair_lt_reg == 8'hff && col_mode_reg == 8'h0f |=>
        COL_OE[3:0] == $past(col_dir_reg[3:0]))
    else $error("Linked column drive not set by column direction");

  upper_od_oe_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      pair_lt_reg[7:4] == 4'h0 && col_dir_reg[7:4] == 4'hf |=>
        COL_OE[7:4] == ~$past(col_level_reg[7:4]))
    else $error("Upper column did not release for a high level");

  row_od_a: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
      row_mode_reg == 8'h00 && pair_lt_reg == 8'h00 |=>
        ROW_OUT == 8'h00 && ROW_OE == $past(row_dir_reg & ~row_level_reg))
    else $error("Open-drain row drove high");
endmodule

/* gvt_pin_load.sv */
`timescale 1ns/1ns
// Board-side loads on the row and column pins
module gvt_pin_load (
  input  wire logic [7:0] ext_row,
  input  wire logic [7:0] ext_row_en,
  input  wire logic [7:0] ext_col,
  input  wire logic [7:0] ext_col_en,
  input  wire logic [7:0] row_out,
  input  wire logic [7:0] row_oe,
  input  wire logic [7:0] col_out,
  input  wire logic [7:0] col_oe,
  output logic      [7:0] row_in,
  output logic      [7:0] col_in
);
  // Every line has a pull-up, so a released line with no outside driver reads high, never stale
  logic [7:0] row_far;
  logic [7:0] col_far;
  assign row_far = (ext_row_en & ext_row) | ~ext_row_en;
  assign col_far = (ext_col_en & ext_col) | ~ext_col_en;
  assign row_in  = (row_oe & row_out) | (~row_oe & row_far);
  assign col_in  = (col_oe & col_out) | (~col_oe & col_far);
endmodule

/* gpio_level_value_translator_bench.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  failures++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
  end end
module gpio_level_value_translator_bench;
  logic       mclk, reset_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, row_in, row_out, row_oe;
  logic [7:0] col_in, col_out, col_oe, row_sup, col_sup, rnd, e, seen;
  logic [7:0] ext_row, ext_col, ext_row_en, ext_col_en;
  logic [7:0] exp_q[$];
  int         sel_q[$];
  int         failures, tests_run, k, s;
  logic [7:0] rst_tab [9];
  string      names [7] = '{"rdata", "row_out", "row_oe", "col_out",
                            "col_oe", "row_sup", "col_sup"};

  gvt_top gvt_top_inst (.MCLK(mclk), .RESET_N(reset_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .ROW_IN(row_in), .ROW_OUT(row_out),
    .ROW_OE(row_oe), .COL_IN(col_in), .COL_OUT(col_out), .COL_OE(col_oe),
    .ROW_SUPPLY_SEL(row_sup), .COL_SUPPLY_SEL(col_sup));
  gvt_pin_load gvt_pin_load_inst (.ext_row(ext_row), .ext_row_en(ext_row_en),
    .ext_col(ext_col), .ext_col_en(ext_col_en), .row_out(row_out),
    .row_oe(row_oe), .col_out(col_out), .col_oe(col_oe), .row_in(row_in),
    .col_in(col_in));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Notes are queued ahead of time; all due notes are settled on this edge
  always @(posedge mclk) begin
    while (sel_q.size() > 0) begin
      s = sel_q.pop_front();
      e = exp_q.pop_front();
      case (s)
        0: seen = reg_rdata;
        1: seen = row_out;
        2: seen = row_oe;
        3: seen = col_out;
        4: seen = col_oe;
        5: seen = row_sup;
        default: seen = col_sup;
      endcase
      `CHK(names[s], e, seen)
    end
  end

  task automatic chk(input int sl, input logic [7:0] ex);
    sel_q.push_back(sl);
    exp_q.push_back(ex);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(0, ex);
  endtask

  // Four edges cover the two-flop sampler plus the output flop
  task automatic settle();
    repeat (4) @(negedge mclk);
  endtask

  task automatic results();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    results();
  end

  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {ext_row, ext_col, ext_row_en, ext_col_en} = '0;
    failures = 0;
    tests_run = 0;
    rst_tab = '{gvt_pkg::ROW_DIR_RST, gvt_pkg::COL_DIR_RST,
      gvt_pkg::ROW_MODE_RST, gvt_pkg::COL_MODE_RST, gvt_pkg::ROW_SUP_RST,
      gvt_pkg::COL_SUP_RST, gvt_pkg::ROW_LVL_RST, gvt_pkg::COL_LVL_RST,
      gvt_pkg::PAIR_LT_RST};
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    for (k = 0; k < 9; k++) begin
      rd(8'h34 + k[7:0], rst_tab[k]);
    end
    chk(5, 8'h00);
    chk(6, 8'h00);
    chk(2, 8'h00);
    chk(4, 8'h00);
    wr(8'h50, 8'hff);
    rd(8'h50, gvt_pkg::UNMAPPED_DATA);
    wr(gvt_pkg::COL_MODE_OFS, 8'hff);
    rd(gvt_pkg::COL_MODE_OFS, gvt_pkg::COL_MODE_WMASK);
    wr(gvt_pkg::ROW_DIR_OFS, 8'hff);
    wr(gvt_pkg::COL_DIR_OFS, 8'hff);
    rnd = 8'h28;
    for (k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      wr(gvt_pkg::ROW_SUP_OFS, rnd);
      wr(gvt_pkg::COL_SUP_OFS, ~rnd);
      wr(gvt_pkg::ROW_LVL_OFS, rnd);
      wr(gvt_pkg::COL_LVL_OFS, ~rnd);
      rd(gvt_pkg::COL_SUP_OFS, ~rnd);
      settle();
      chk(5, rnd);
      chk(6, ~rnd);
      chk(1, rnd);
      chk(2, 8'hff);
      chk(3, {4'h0, ~rnd[3:0]});
      chk(4, {rnd[7:4], 4'hf});
    end
    // Open-drain rows only pull low; a high level just releases the pin
    wr(gvt_pkg::ROW_MODE_OFS, 8'h00);
    settle();
    chk(1, 8'h00);
    chk(2, ~rnd);
    wr(gvt_pkg::ROW_MODE_OFS, 8'hff);
    // Linked pairs must ignore the row direction bits, here all inputs
    wr(gvt_pkg::ROW_DIR_OFS, 8'h00);
    wr(gvt_pkg::COL_DIR_OFS, 8'h00);
    wr(gvt_pkg::PAIR_LT_OFS, 8'hff);
    ext_col_en = 8'hff;
    for (k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      ext_col = rnd;
      settle();
      chk(1, rnd);
      chk(2, 8'hff);
      chk(4, 8'h00);
    end
    ext_col_en = 8'h00;
    ext_row_en = 8'hff;
    wr(gvt_pkg::COL_DIR_OFS, 8'hff);
    for (k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      ext_row = rnd;
      settle();
      chk(3, {4'h0, rnd[3:0]});
      chk(4, {~rnd[7:4], 4'hf});
      chk(2, 8'h00);
    end
    wr(gvt_pkg::PAIR_LT_OFS, 8'h00);
    wr(gvt_pkg::COL_DIR_OFS, 8'h00);
    rd(gvt_pkg::PAIR_LT_OFS, 8'h00);
    settle();
    chk(2, 8'h00);
    chk(4, 8'h00);
    @(negedge mclk);
    results();
  end
endmodule
